// File: verilog/rcs_pkg.sv
// Constants, register map and decode helpers of the read command spacing block
package rcs_pkg;

  // --------------------------------------------------------------------
  // Register map (APB byte addresses)
  // --------------------------------------------------------------------
  localparam logic [11:0] RCS_MODE_OFF = 12'h000;
  localparam logic [11:0] RCS_LAT_OFF = 12'h004;
  localparam logic [11:0] RCS_STAT_OFF = 12'h008;
  localparam logic [11:0] RCS_RDCNT_OFF = 12'h00C;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int RCS_MODE_BURST_LSB = 0;
  localparam int RCS_MODE_RTP_LSB = 9;
  localparam int RCS_LAT_CL_LSB = 0;
  localparam int RCS_LAT_CWL_LSB = 5;
  localparam int RCS_LAT_AL_LSB = 10;
  localparam int RCS_LAT_PL_LSB = 12;
  localparam int RCS_LAT_DBI_BIT = 16;
  localparam int RCS_LAT_PAR_BIT = 17;
  localparam int RCS_LAT_RPRE_BIT = 18;
  localparam int RCS_LAT_WPRE_BIT = 19;
  localparam int RCS_STAT_RL_LSB = 0;
  localparam int RCS_STAT_WL_LSB = 7;
  localparam int RCS_STAT_CHOP_BIT = 14;
  localparam int RCS_STAT_BUSY_BIT = 15;
  localparam int RCS_STAT_ERR_BIT = 16;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [11:0] RCS_MODE_RST = 12'h000;
  localparam logic [19:0] RCS_LAT_RST = 20'h0012B;

  // --------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------
  localparam logic [1:0] RCS_BURST_FIXED8 = 2'h0;
  localparam logic [1:0] RCS_BURST_OTF = 2'h1;
  localparam logic [1:0] RCS_BURST_FIXED4 = 2'h2;
  localparam logic [1:0] RCS_AL_OFF = 2'h0;
  localparam logic [1:0] RCS_AL_CL_MINUS = 2'h1;
  localparam logic [2:0] RCS_RTP_CODE_6 = 3'h1;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int RCS_CLK_PERIOD_PS = 4000;
  localparam int RCS_RTP_MIN_PS = 7500;
  localparam int RCS_RTP_MIN_CK = 4;
  localparam int RCS_RTP_NS_CYC =
    (RCS_RTP_MIN_PS + RCS_CLK_PERIOD_PS - 1) / RCS_CLK_PERIOD_PS;
  localparam logic [6:0] RCS_RTP_MIN_CYC = 7'(
    (RCS_RTP_NS_CYC > RCS_RTP_MIN_CK) ? RCS_RTP_NS_CYC : RCS_RTP_MIN_CK);
  localparam logic [6:0] RCS_RTP_CODE_6_CYC = 7'h06;
  localparam logic [6:0] RCS_AL_CL_OFFSET = 7'h02;
  localparam logic [6:0] RCS_DBI_ADDER = 7'h02;
  localparam logic [3:0] RCS_BL8_CLKS = 4'h4;
  localparam logic [3:0] RCS_BC4_CLKS = 4'h2;
  localparam logic [3:0] RCS_POST_CLKS = 4'h1;
  localparam logic [3:0] RCS_PRE1_CLKS = 4'h1;
  localparam logic [3:0] RCS_PRE2_CLKS = 4'h2;
  localparam int RCS_PIPE_DEPTH = 128;
  localparam int RCS_NUM_BANKS = 16;

  // Chopped four-beat burst decode from the burst field and address bit
  function automatic logic rcs_is_chop(input logic [1:0] field,
                                       input logic bc_bit);
    rcs_is_chop = (field == RCS_BURST_FIXED4) ||
                  ((field == RCS_BURST_OTF) && !bc_bit);
  endfunction

  // Recovery for auto-precharge, never below the internal minimum
  function automatic logic [6:0] rcs_rtp_cyc(input logic [2:0] code);
    logic [6:0] tbl;
    tbl = (code == RCS_RTP_CODE_6) ? RCS_RTP_CODE_6_CYC : RCS_RTP_MIN_CYC;
    rcs_rtp_cyc = (tbl < RCS_RTP_MIN_CYC) ? RCS_RTP_MIN_CYC : tbl;
  endfunction

  // Pipe stage that shows an event a given number of cycles late
  function automatic logic [6:0] rcs_tap_idx(input logic [6:0] lat);
    rcs_tap_idx = (lat == 7'h00) ? 7'h00 : lat - 7'h01;
  endfunction

endpackage

// File: verilog/rcs_lat_pipe.sv
// Latency pipeline carrying read and write events toward their data slots
`timescale 1ns/1ps
module rcs_lat_pipe
  import rcs_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic in_rd,
  input logic in_wr,
  input logic in_chop,
  input logic [6:0] tap_rd,
  input logic [6:0] tap_wr,
  input logic [6:0] tap_al,
  output logic rd_hit,
  output logic rd_chop,
  output logic wr_hit,
  output logic wr_chop,
  output logic al_hit
);

  // --------------------------------------------------------------------
  // Shift array: bit 2 read, bit 1 write, bit 0 chop
  // --------------------------------------------------------------------
  logic [2:0] stage [RCS_PIPE_DEPTH];
  logic [2:0] rd_tap;
  logic [2:0] wr_tap;
  logic [2:0] al_tap;

  // A full shift register trades area for any number of reads in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RCS_PIPE_DEPTH; i++) begin
        stage[i] <= 3'h0;
      end
    end else if (ce) begin
      stage[0] <= {in_rd, in_wr, in_chop};
      for (int i = 1; i < RCS_PIPE_DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  // Tap selection
  assign rd_tap = stage[rcs_tap_idx(tap_rd)];
  assign wr_tap = stage[rcs_tap_idx(tap_wr)];
  assign al_tap = stage[rcs_tap_idx(tap_al)];
  assign rd_hit = rd_tap[2];
  assign rd_chop = rd_tap[0];
  assign wr_hit = wr_tap[1];
  assign wr_chop = wr_tap[0];
  assign al_hit = al_tap[2];

endmodule

// File: verilog/rcs_burst_gen.sv
// Data bus window generator: preamble, data beats and postamble
`timescale 1ns/1ps
module rcs_burst_gen
  import rcs_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic start,
  input logic chop,
  input logic pre2,
  output logic bus_oe,
  output logic data_valid,
  output logic chop_out
);

  // --------------------------------------------------------------------
  // Phase machine
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    RCS_IDLE = 4'h1,
    RCS_PRE = 4'h2,
    RCS_DATA = 4'h4,
    RCS_POST = 4'h8
  } rcs_phase_e;

  rcs_phase_e phase;
  rcs_phase_e next_phase;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_chop;
  logic [3:0] data_clks;
  logic [3:0] pre_clks;

  assign data_clks = chop_out ? RCS_BC4_CLKS : RCS_BL8_CLKS;
  assign pre_clks = pre2 ? RCS_PRE2_CLKS : RCS_PRE1_CLKS;

  // A new start restarts the window; spacing is the controller's duty
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_chop = chop_out;
    if (start) begin
      next_phase = RCS_PRE;
      next_cnt = pre_clks;
      next_chop = chop;
    end else begin
      case (phase)
        RCS_IDLE: begin
          next_cnt = 4'h0;
        end
        RCS_PRE: begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_phase = RCS_DATA;
            next_cnt = data_clks;
          end
        end
        RCS_DATA: begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_phase = RCS_POST;
            next_cnt = RCS_POST_CLKS;
          end
        end
        RCS_POST: begin
          next_cnt = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_phase = RCS_IDLE;
          end
        end
        default: begin
          next_phase = RCS_IDLE;
          next_cnt = 4'h0;
        end
      endcase
    end
  end

  // Phase state and window outputs, all from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= RCS_IDLE;
      cnt <= 4'h0;
      chop_out <= 1'b0;
    end else if (ce) begin
      phase <= next_phase;
      cnt <= next_cnt;
      chop_out <= next_chop;
    end
  end

  assign bus_oe = (phase != RCS_IDLE);
  assign data_valid = (phase == RCS_DATA);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_four_beats: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && phase == RCS_PRE && next_phase == RCS_DATA && chop_out)
      |=> data_valid [*2] ##1 (phase == RCS_POST || !ce || start))
    else $error("chopped burst data window not two clocks");
  a_eight_beats: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && phase == RCS_PRE && next_phase == RCS_DATA && !chop_out &&
     !start) |=> data_valid [*4] ##1 !data_valid)
    else $error("eight-beat data window ended early");
  c_chop_burst: cover property (@(posedge pclk) disable iff (!presetn)
    data_valid && chop_out);

endmodule

// File: verilog/rcs_read_spacing.sv
// Read command spacing core: burst decode, latencies and precharge timing
`timescale 1ns/1ps
module rcs_read_spacing
  import rcs_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic cmd_valid,
  input logic cmd_read,
  input logic cmd_write,
  input logic cmd_precharge,
  input logic [3:0] cmd_bank,
  input logic cmd_burst_chop_select_bit,
  input logic cmd_auto_precharge,
  output logic rd_bus_oe,
  output logic rd_data_valid,
  output logic rd_chop,
  output logic wr_bus_accept,
  output logic wr_data_valid,
  output logic wr_chop,
  output logic internal_read,
  output logic [15:0] ap_precharge
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [11:0] mode_register_zero;
  logic [19:0] lat_cfg;
  logic spacing_err;
  logic last_chop;
  logic [31:0] rd_count;
  logic [7:0] guard [RCS_NUM_BANKS];
  logic [15:0] ap_arm;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  wire sel_mode = (paddr == RCS_MODE_OFF);
  wire sel_lat = (paddr == RCS_LAT_OFF);
  wire sel_stat = (paddr == RCS_STAT_OFF);
  wire sel_cnt = (paddr == RCS_RDCNT_OFF);
  wire addr_hit = sel_mode || sel_lat || sel_stat || sel_cnt;
  wire apb_setup = psel && !penable && ce;
  wire apb_wr = psel && penable && pwrite && ce && addr_hit;
  wire err_clr = apb_wr && sel_stat && pwdata[RCS_STAT_ERR_BIT];

  // Frozen clock enable also holds the bus, so no access slips through
  assign pready = ce;
  assign pslverr = psel && penable && !addr_hit;

  // --------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------
  wire [1:0] burst_field = mode_register_zero[RCS_MODE_BURST_LSB +: 2];
  wire [2:0] rtp_code = mode_register_zero[RCS_MODE_RTP_LSB +: 3];
  wire [4:0] cas_latency = lat_cfg[RCS_LAT_CL_LSB +: 5];
  wire [4:0] write_cas_latency = lat_cfg[RCS_LAT_CWL_LSB +: 5];
  wire [1:0] al_mode = lat_cfg[RCS_LAT_AL_LSB +: 2];
  wire [2:0] parity_latency = lat_cfg[RCS_LAT_PL_LSB +: 3];
  wire data_bus_inversion = lat_cfg[RCS_LAT_DBI_BIT];
  wire parity_en = lat_cfg[RCS_LAT_PAR_BIT];
  wire rd_pre2 = lat_cfg[RCS_LAT_RPRE_BIT];
  wire wr_pre2 = lat_cfg[RCS_LAT_WPRE_BIT];

  // --------------------------------------------------------------------
  // Latency arithmetic
  // --------------------------------------------------------------------
  wire [6:0] cl7 = {2'h0, cas_latency};
  wire [6:0] additive_latency = (al_mode == RCS_AL_CL_MINUS) ?
    cl7 - RCS_AL_CL_OFFSET : 7'h00;
  wire [6:0] pl_add = parity_en ? {4'h0, parity_latency} : 7'h00;
  wire [6:0] dbi_add = data_bus_inversion ? RCS_DBI_ADDER : 7'h00;
  wire [6:0] read_latency = cl7 + additive_latency + pl_add + dbi_add;
  wire [6:0] write_latency = {2'h0, write_cas_latency} + additive_latency +
    pl_add;
  wire [6:0] rtp_cyc = rcs_rtp_cyc(rtp_code);
  wire [7:0] guard_load = {1'b0, additive_latency} + {1'b0, rtp_cyc};
  wire [6:0] rd_pre_clks = rd_pre2 ? {3'h0, RCS_PRE2_CLKS} :
    {3'h0, RCS_PRE1_CLKS};
  wire [6:0] wr_pre_clks = wr_pre2 ? {3'h0, RCS_PRE2_CLKS} :
    {3'h0, RCS_PRE1_CLKS};
  wire [6:0] rd_tap = read_latency - rd_pre_clks;
  wire [6:0] wr_tap = write_latency - wr_pre_clks;

  // --------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------
  wire cmd_rd = cmd_valid && cmd_read && ce;
  wire cmd_wr = cmd_valid && cmd_write && ce;
  wire cmd_pre = cmd_valid && cmd_precharge && ce;
  wire cmd_chop = rcs_is_chop(burst_field,
    cmd_burst_chop_select_bit);

  logic rd_start;
  logic rd_start_chop;
  logic wr_start;
  logic wr_start_chop;
  logic al_hit;

  // Internal read lands additive latency after the external command
  assign internal_read = (additive_latency == 7'h00) ? cmd_rd : al_hit;

  rcs_lat_pipe u_pipe (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_rd(cmd_rd),
    .in_wr(cmd_wr),
    .in_chop(cmd_chop),
    .tap_rd(rd_tap),
    .tap_wr(wr_tap),
    .tap_al(additive_latency),
    .rd_hit(rd_start),
    .rd_chop(rd_start_chop),
    .wr_hit(wr_start),
    .wr_chop(wr_start_chop),
    .al_hit(al_hit)
  );

  // Read data drive window, sized by the burst decode
  rcs_burst_gen u_rd_burst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(rd_start),
    .chop(rd_start_chop),
    .pre2(rd_pre2),
    .bus_oe(rd_bus_oe),
    .data_valid(rd_data_valid),
    .chop_out(rd_chop)
  );

  // Write data accept window, same shape as reads
  rcs_burst_gen u_wr_burst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(wr_start),
    .chop(wr_start_chop),
    .pre2(wr_pre2),
    .bus_oe(wr_bus_accept),
    .data_valid(wr_data_valid),
    .chop_out(wr_chop)
  );

  // --------------------------------------------------------------------
  // Per-bank read-to-precharge guards and auto-precharge
  // --------------------------------------------------------------------
  logic [15:0] fire_vec;
  logic [15:0] guard_busy;
  always_comb begin
    for (int i = 0; i < RCS_NUM_BANKS; i++) begin
      fire_vec[i] = ap_arm[i] && (guard[i] == 8'h01);
      guard_busy[i] = (guard[i] > 8'h01);
    end
  end

  // Auto-precharge begins in the cycle the guard would allow it
  assign ap_precharge = ce ? fire_vec : 16'h0000;

  // Early precharge from the controller is flagged, not blocked
  wire early_pre = cmd_pre && guard_busy[cmd_bank];

  // Guard countdown: a read reloads, otherwise count toward zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RCS_NUM_BANKS; i++) begin
        guard[i] <= 8'h00;
      end
      ap_arm <= 16'h0000;
    end else if (ce) begin
      for (int i = 0; i < RCS_NUM_BANKS; i++) begin
        if (cmd_rd && (cmd_bank == 4'(i))) begin
          guard[i] <= guard_load;
          ap_arm[i] <= cmd_auto_precharge;
        end else begin
          if (guard[i] != 8'h00) begin
            guard[i] <= guard[i] - 8'h01;
          end
          if (fire_vec[i]) begin
            ap_arm[i] <= 1'b0;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Register writes and status
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_register_zero <= RCS_MODE_RST;
      lat_cfg <= RCS_LAT_RST;
    end else if (apb_wr) begin
      if (sel_mode) begin
        mode_register_zero <= pwdata[11:0];
      end
      if (sel_lat) begin
        lat_cfg <= pwdata[19:0];
      end
    end
  end

  // Sticky error: a new violation wins over the clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spacing_err <= 1'b0;
      last_chop <= 1'b0;
      rd_count <= 32'h0000_0000;
    end else if (ce) begin
      if (early_pre) begin
        spacing_err <= 1'b1;
      end else if (err_clr) begin
        spacing_err <= 1'b0;
      end
      if (cmd_rd || cmd_wr) begin
        last_chop <= cmd_chop;
      end
      if (cmd_rd) begin
        rd_count <= rd_count + 32'h0000_0001;
      end
    end
  end

  // Read data is latched in the setup phase and shown in the access phase
  wire [31:0] stat_word = {15'h0000, spacing_err, rd_bus_oe, last_chop,
    write_latency, read_latency};
  wire [31:0] rd_mux = sel_mode ? {20'h00000, mode_register_zero} :
    sel_lat ? {12'h000, lat_cfg} :
    sel_stat ? stat_word :
    sel_cnt ? rd_count : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_fixed8_decode: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_field == RCS_BURST_FIXED8 && cmd_rd) |=> !last_chop)
    else $error("fixed eight-beat read recorded as chopped");
  a_otf_chop: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_field == RCS_BURST_OTF && cmd_wr && !cmd_burst_chop_select_bit)
      |=> last_chop)
    else $error("on-the-fly chop bit low did not chop");
  a_fixed4_chop: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_field == RCS_BURST_FIXED4 && cmd_rd) |=> last_chop)
    else $error("fixed four-beat mode did not chop");
  a_rtp_floor: assert property (@(posedge pclk) disable iff (!presetn)
    rtp_cyc >= RCS_RTP_MIN_CYC)
    else $error("read-to-precharge below its minimum");
  a_rtp_code_six: assert property (@(posedge pclk) disable iff (!presetn)
    (rtp_code == RCS_RTP_CODE_6) |-> (rtp_cyc == 7'h06))
    else $error("recovery code 001 not six clocks");
  a_dbi_adder: assert property (@(posedge pclk) disable iff (!presetn)
    (data_bus_inversion && !parity_en)
      |-> (read_latency == cl7 + additive_latency + 7'h02))
    else $error("inversion adder not two clocks");
  a_parity_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (parity_en && !data_bus_inversion) |->
      (read_latency == cl7 + additive_latency + {4'h0, parity_latency}))
    else $error("parity latency missing from read latency");
  a_al_internal: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmd_rd && additive_latency == 7'h09 && $stable(lat_cfg))
      |-> ##9 (internal_read || !ce || $changed(lat_cfg)))
    else $error("internal read not delayed by additive latency");
  a_ap_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cmd_rd && cmd_auto_precharge && guard_load == 8'h06 &&
     cmd_bank == 4'h0) ##1 (ce && !(cmd_rd && cmd_bank == 4'h0)) [*6]
      |-> ap_precharge[0])
    else $error("auto-precharge not at additive latency plus recovery");
  a_early_flag: assert property (@(posedge pclk) disable iff (!presetn)
    early_pre |=> spacing_err)
    else $error("early precharge not flagged");

  c_otf_chop_read: cover property (@(posedge pclk) disable iff (!presetn)
    cmd_rd && burst_field == RCS_BURST_OTF && cmd_chop);
  c_auto_pre: cover property (@(posedge pclk) disable iff (!presetn)
    ap_precharge != 16'h0000);
  c_early_pre: cover property (@(posedge pclk) disable iff (!presetn)
    early_pre);
  c_al_read: cover property (@(posedge pclk) disable iff (!presetn)
    internal_read && additive_latency != 7'h00);

endmodule

// File: verification/rcs_ctrl_model.sv
// Memory controller model issuing commands to the read spacing block
`timescale 1ns/1ps
module rcs_ctrl_model (
  input wire logic pclk,
  output logic cmd_valid,
  output logic cmd_read,
  output logic cmd_write,
  output logic cmd_precharge,
  output logic [3:0] cmd_bank,
  output logic cmd_burst_chop_select_bit,
  output logic cmd_auto_precharge
);
  int cyc = 0;
  int last_rd [16];
  int gap = 4;
  // Row timing in clocks; the row cycle figure is a plain default
  int last_pre [16];
  int last_act [16];
  int precharge_period = 11;
  int row_cycle_time = 40;
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_write = 1'b0;
    cmd_precharge = 1'b0;
    cmd_bank = 4'h0;
    cmd_burst_chop_select_bit = 1'b0;
    cmd_auto_precharge = 1'b0;
  end
  // Per-bank read time stamps; strobe lasts one cycle
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cmd_valid && cmd_read) begin
      last_rd[cmd_bank] <= cyc;
    end
    if (cmd_valid && cmd_precharge) begin
      last_pre[cmd_bank] <= cyc;
    end
    if (cmd_valid) begin
      cmd_valid <= 1'b0;
    end
  end
  task automatic start(input logic rd, input logic pre, input logic [3:0] b,
                       input logic bc, input logic ap);
    @(posedge pclk);
    while (cmd_valid === 1'b1) @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_write <= !rd && !pre;
    cmd_precharge <= pre;
    cmd_bank <= b;
    cmd_burst_chop_select_bit <= bc;
    cmd_auto_precharge <= ap;
  endtask
  // Gap covers AL plus recovery; the row is assumed open long enough
  task automatic prech(input logic [3:0] b, input logic early);
    repeat (2) @(posedge pclk);
    while (!early && cyc - last_rd[b] < gap) @(posedge pclk);
    start(1'b0, 1'b1, b, 1'b0, 1'b0);
  endtask
  // No activate pin here: the row is reopened off this interface
  task automatic act_wait(input logic [3:0] b);
    while (cyc - last_pre[b] < precharge_period || cyc - last_act[b] < row_cycle_time)
      @(posedge pclk);
    last_act[b] = cyc;
  endtask
endmodule

// File: verification/rcs_read_spacing_tb.sv
// Self-checking bench of the read command spacing block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module rcs_read_spacing_tb import rcs_pkg::*;;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic cv, cr, cw, cp, cbc, cap, rd_data_valid, internal_read;
  logic oe, wv, wa, rc, wc;
  logic [3:0] cb;
  logic [15:0] ap_precharge;
  int n_errors = 0, n_checks = 0, f, l;
  rcs_ctrl_model i_rcs_ctrl_model (.pclk(pclk), .cmd_valid(cv),
    .cmd_read(cr), .cmd_write(cw), .cmd_precharge(cp), .cmd_bank(cb),
    .cmd_burst_chop_select_bit(cbc), .cmd_auto_precharge(cap));
  rcs_read_spacing i_rcs_read_spacing (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cv), .cmd_read(cr), .cmd_write(cw), .cmd_precharge(cp),
    .cmd_bank(cb), .cmd_burst_chop_select_bit(cbc), .cmd_auto_precharge(cap),
    .rd_bus_oe(oe), .rd_data_valid(rd_data_valid), .rd_chop(rc),
    .wr_bus_accept(wa), .wr_data_valid(wv), .wr_chop(wc),
    .internal_read(internal_read), .ap_precharge(ap_precharge));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    repeat (20) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Read command (a write for sel 4 and 5), then first cycle and length of the chosen output
  task automatic rd_meas(input int sel, input logic bc, input logic ap);
    logic [5:0] v;
    i_rcs_ctrl_model.start(sel < 4, 1'b0, 4'h0, bc, ap);
    f = -1;
    l = 0;
    for (int k = 0; k < 40; k++) begin
      #1;
      v = {wa, wv, oe, |ap_precharge, internal_read, rd_data_valid};
      if (v[sel] === 1'b1) begin
        // A flop launched at edge n shows one sample after a command strobe
        if (f < 0) f = (sel == 0 || sel > 2) ? k - 1 : k;
        l++;
      end
      @(posedge pclk);
    end
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, RCS_LAT_OFF, 32'h0);
    `CHK("lat", 32'h0012B, q)
    apb(1'b0, RCS_STAT_OFF, 32'h0);
    `CHK("rl", 7'h0B, q[6:0])
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_burst;
    logic [1:0] fld [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic bc [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int n [5] = '{4, 4, 2, 2, 4};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, RCS_MODE_OFF, {30'h0, fld[i]});
      rd_meas(0, bc[i], 1'b0);
      `CHK("start", 11, f)
      `CHK("beats", n[i], l)
      rd_meas(4, bc[i], 1'b0);
      `CHK("wstart", 9, f)
      `CHK("wbeats", n[i], l)
      `CHK("chop", {2{n[i] == 2}}, {rc, wc})
    end
  endtask
  task automatic t_lat;
    logic [31:0] lat [3] = '{32'h52B, 32'h1012B, 32'h2412B};
    int rl [3] = '{20, 13, 15};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, RCS_LAT_OFF, lat[i]);
      rd_meas(0, 1'b1, 1'b0);
      `CHK("rl", rl[i], f)
    end
    apb(1'b1, RCS_LAT_OFF, 32'h52B);
    rd_meas(1, 1'b1, 1'b0);
    `CHK("iread", 9, f)
    apb(1'b1, RCS_LAT_OFF, 32'h4012B);
    rd_meas(3, 1'b1, 1'b0);
    `CHK("oe2", 9, f)
    `CHK("oelen", 7, l)
    apb(1'b1, RCS_LAT_OFF, 32'h8014B);
    rd_meas(5, 1'b1, 1'b0);
    `CHK("acc2", 8, f)
    `CHK("acclen", 7, l)
  endtask
  task automatic t_ap;
    logic [31:0] md [3] = '{32'h200, 32'h0, 32'h200};
    logic [31:0] lat [3] = '{32'h12B, 32'h12B, 32'h52B};
    int e [3] = '{6, 4, 15};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, RCS_MODE_OFF, md[i]);
      apb(1'b1, RCS_LAT_OFF, lat[i]);
      rd_meas(2, 1'b1, 1'b1);
      `CHK("ap", e[i], f)
    end
    apb(1'b1, RCS_LAT_OFF, 32'h12B);
    apb(1'b1, RCS_MODE_OFF, 32'h0);
  endtask
  task automatic t_early;
    i_rcs_ctrl_model.start(1'b1, 1'b0, 4'h5, 1'b1, 1'b0);
    i_rcs_ctrl_model.prech(4'h5, 1'b1);
    repeat (3) @(posedge pclk);
    apb(1'b0, RCS_STAT_OFF, 32'h0);
    `CHK("early", 1'b1, q[16])
    apb(1'b1, RCS_STAT_OFF, 32'h10000);
    i_rcs_ctrl_model.act_wait(4'h5);
    i_rcs_ctrl_model.start(1'b1, 1'b0, 4'h5, 1'b1, 1'b0);
    i_rcs_ctrl_model.prech(4'h5, 1'b0);
    repeat (3) @(posedge pclk);
    apb(1'b0, RCS_STAT_OFF, 32'h0);
    `CHK("legal", 1'b0, q[16])
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_burst();
    t_lat();
    t_ap();
    t_early();
    report_and_stop();
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule
